/* File: verilog/signalling_indirect_access.sv */
// Indirect register access into the receive signalling extractor
// Summary of operation
// - Address/control write launches one internal access, only in indirect mode and when none is running
// - Top bit one reads, zero writes
// - Read result lands in buffer within 640 ns
// - Bank bit picks options or signalling data
// - 01H-18H signalling data, 19H-1FH ignored
// - 20H configuration, 21H-38H options, rest ignored
// - Signalling read returns A B C D low
// - Non-ESF formats return C=A, D=B
// - Returned state from third-to-last superframe
// - Debounced state needs two matching superframes
// - Option bit 3 inverts channel data only
// - Option bit 2 fixes the byte LSB unless non-ESF extraction is off
// - Option bit 1 level, reversed under inversion
// - Option bit 0 enables signalling debounce
// - Busy flag high while access runs
// - Per-channel functions need global enable
`timescale 1ns/10ps
`default_nettype none
module signalling_indirect_access #(
  parameter int CHANNELS      = signalling_pkg::CHANNELS,
  parameter int ACCESS_CYCLES = signalling_pkg::ACCESS_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           cpu_addr,
  input  wire logic [7:0]           cpu_wdata,
  input  wire logic                 cpu_wr,
  input  wire logic                 cpu_rd,
  output logic [7:0]                cpu_rdata,
  input  wire logic                 rx_valid,
  input  wire signalling_pkg::pcm_s rx_word,
  input  wire logic                 rx_superframe_end,
  output logic                      out_valid,
  output signalling_pkg::pcm_s      out_word
);

  localparam logic [signalling_pkg::COUNT_W-1:0] ACCESS_COUNT =
    signalling_pkg::COUNT_W'(ACCESS_CYCLES);
  localparam logic [signalling_pkg::COUNT_W-1:0] COUNT_ONE = 7'h01;

  typedef struct packed {
    logic [signalling_pkg::CFG_W-1:0]         config_bits;
    logic [7:0]                               ctrl;
    logic [signalling_pkg::NIBBLE_W-1:0]      data;
    signalling_pkg::access_state_e            access;
    logic [signalling_pkg::COUNT_W-1:0]       count;
    logic [CHANNELS-1:0][3:0]                 options;
    logic [7:0]                               rdata;
    logic                                     out_valid;
    signalling_pkg::pcm_s                     out_word;
  } main_s;

  main_s state_reg;
  main_s state_next;

  logic [signalling_pkg::CTRL_ADDR_W-1:0] int_addr;
  logic [signalling_pkg::CHAN_W-1:0]      int_chan;
  logic                                   int_read;
  logic                                   esf_mode;
  logic                                   extract_off;
  logic                                   chan_enable;
  logic                                   busy;
  logic [3:0]                             sig_state;
  logic [3:0]                             sig_return;
  logic [CHANNELS-1:0]                    debounce_mask;
  logic                                   rx_channel_ok;
  logic [signalling_pkg::CHAN_W-1:0]      rx_chan;
  logic                                   capture_en;
  logic                                   capture_bit;

  assign int_addr    = state_reg.ctrl[signalling_pkg::CTRL_ADDR_W-1:0];
  assign int_chan    = signalling_pkg::chan_index(int_addr);
  assign int_read    = state_reg.ctrl[signalling_pkg::CTRL_RW_BIT];
  assign esf_mode    = state_reg.config_bits[signalling_pkg::CFG_ESF_BIT];
  assign extract_off = !esf_mode && state_reg.config_bits[signalling_pkg::CFG_EXTRACT_OFF_BIT];
  assign chan_enable = state_reg.config_bits[signalling_pkg::CFG_CHAN_ENABLE_BIT];
  assign busy        = (state_reg.access == signalling_pkg::ACCESS_RUN);

  // Receive channel numbers 1..N are data timeslots; 0 marks the framing bit
  assign rx_channel_ok = (rx_word.channel != '0) &&
                         (rx_word.channel <= signalling_pkg::CHAN_W'(CHANNELS));
  assign rx_chan       = rx_word.channel - 5'h01;
  assign capture_en    = rx_valid && rx_channel_ok && rx_word.sig_frame;
  // Extraction disabled forces the captured stream to zero
  assign capture_bit   = extract_off ? 1'b0 : rx_word.data[0];

  always_comb begin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      debounce_mask[ch] = chan_enable &&
                          state_reg.options[ch][signalling_pkg::OPT_DEBOUNCE_BIT];
    end
  end

  // C mirrors A and D mirrors B outside the extended superframe format
  always_comb begin
    sig_return = sig_state;
    if (!esf_mode) begin
      sig_return[signalling_pkg::SIG_C_BIT] = sig_state[signalling_pkg::SIG_A_BIT];
      sig_return[signalling_pkg::SIG_D_BIT] = sig_state[signalling_pkg::SIG_B_BIT];
    end
  end

  signalling_history #(
    .CHANNELS (CHANNELS)
  ) u_history (
    .clock           (clock),
    .rst_n           (rst_n),
    .capture_en      (capture_en),
    .capture_channel (rx_chan),
    .capture_index   (rx_word.sig_index),
    .capture_bit     (capture_bit),
    .superframe_end  (rx_superframe_end),
    .debounce_mask   (debounce_mask),
    .read_channel    (int_chan),
    .read_state      (sig_state)
  );

  // Receive byte processing in the channel's own timeslot
  function automatic logic [7:0] process_byte(
    input logic [7:0] data,
    input logic [3:0] opt,
    input logic       fix_allowed
  );
    logic [7:0] result;
    logic       invert;
    logic       level;
    result = data;
    invert = opt[signalling_pkg::OPT_INVERT_BIT];
    level  = opt[signalling_pkg::OPT_LEVEL_BIT];
    if (invert) begin
      result = ~data;
    end
    if (opt[signalling_pkg::OPT_FIX_BIT] && fix_allowed) begin
      result[0] = invert ? ~level : level;
    end
    process_byte = result;
  endfunction : process_byte

  always_comb begin
    state_next           = state_reg;
    state_next.out_valid = rx_valid;

    // Receive stream; framing bits and disabled per-channel mode pass unchanged
    if (rx_valid) begin
      state_next.out_word = rx_word;
      if (rx_channel_ok && chan_enable) begin
        state_next.out_word.data = process_byte(rx_word.data,
                                                state_reg.options[rx_chan],
                                                !extract_off);
      end
    end

    // Direct register reads
    if (cpu_rd) begin
      if (cpu_addr == signalling_pkg::ADDR_CONFIG) begin
        state_next.rdata = {3'h0, state_reg.config_bits};
      end else if (cpu_addr == signalling_pkg::ADDR_STATUS) begin
        state_next.rdata = '0;
        state_next.rdata[signalling_pkg::STATUS_BUSY_BIT] = busy;
      end else if (cpu_addr == signalling_pkg::ADDR_IND_CTRL) begin
        state_next.rdata = state_reg.ctrl;
      end else if (cpu_addr == signalling_pkg::ADDR_IND_DATA) begin
        state_next.rdata = {4'h0, state_reg.data};
      end else begin
        state_next.rdata = '0;
      end
    end

    // Indirect access completion
    if (busy) begin
      if (state_reg.count == COUNT_ONE) begin
        state_next.access = signalling_pkg::ACCESS_IDLE;
        state_next.count  = '0;
        if (state_reg.ctrl[signalling_pkg::CTRL_BANK_BIT]) begin
          // Configuration bank
          if (int_addr == signalling_pkg::INT_CONFIG) begin
            if (int_read) begin
              state_next.data = state_reg.config_bits[signalling_pkg::NIBBLE_W-1:0];
            end else begin
              state_next.config_bits[signalling_pkg::NIBBLE_W-1:0] = state_reg.data;
            end
          end else if (int_addr <= signalling_pkg::INT_OPT_LAST) begin
            if (int_read) begin
              state_next.data = state_reg.options[int_chan];
            end else begin
              state_next.options[int_chan] = state_reg.data;
            end
          end
        end else begin
          // Signalling bank is read-only; out-of-range addresses are ignored
          if (int_addr >= signalling_pkg::INT_SIG_FIRST &&
              int_addr <= signalling_pkg::INT_SIG_LAST && int_read) begin
            state_next.data = sig_return;
          end
        end
      end else begin
        state_next.count = state_reg.count - COUNT_ONE;
      end
    end

    // Direct register writes
    if (cpu_wr) begin
      if (cpu_addr == signalling_pkg::ADDR_CONFIG) begin
        state_next.config_bits = cpu_wdata[signalling_pkg::CFG_W-1:0];
      end else if (cpu_addr == signalling_pkg::ADDR_IND_CTRL) begin
        state_next.ctrl = cpu_wdata & signalling_pkg::CTRL_WRITE_MASK;
        // Launch only in indirect mode and when no access is running
        if (state_reg.config_bits[signalling_pkg::CFG_INDIRECT_BIT] && !busy) begin
          state_next.access = signalling_pkg::ACCESS_RUN;
          state_next.count  = ACCESS_COUNT;
        end
      end else if (cpu_addr == signalling_pkg::ADDR_IND_DATA) begin
        state_next.data = cpu_wdata[signalling_pkg::NIBBLE_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg             <= '0;
      state_reg.config_bits <= signalling_pkg::CFG_RESET;
      state_reg.ctrl        <= signalling_pkg::CTRL_RESET;
      state_reg.data        <= signalling_pkg::NIBBLE_RESET;
      state_reg.access      <= signalling_pkg::ACCESS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cpu_rdata = state_reg.rdata;
  assign out_valid = state_reg.out_valid;
  assign out_word  = state_reg.out_word;

endmodule : signalling_indirect_access
`default_nettype wire

/* File: verilog/signalling_pkg.sv */
// Shared constants and types for the signalling extractor indirect access path
package signalling_pkg;

  localparam int CHANNELS = 24;
  localparam int CHAN_W   = 5;

  // Directly addressed microprocessor registers
  localparam logic [7:0] ADDR_CONFIG   = 8'h40;
  localparam logic [7:0] ADDR_STATUS   = 8'h41;
  localparam logic [7:0] ADDR_IND_CTRL = 8'h42;
  localparam logic [7:0] ADDR_IND_DATA = 8'h43;

  // Extractor configuration fields
  localparam int CFG_ESF_BIT         = 4;
  localparam int CFG_FORMAT_BIT      = 3;
  localparam int CFG_EXTRACT_OFF_BIT = 2;
  localparam int CFG_INDIRECT_BIT    = 1;
  localparam int CFG_CHAN_ENABLE_BIT = 0;
  localparam int CFG_W        = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // Status and indirect address/control fields
  localparam int STATUS_BUSY_BIT = 7;
  localparam int CTRL_RW_BIT     = 7;
  localparam int CTRL_BANK_BIT   = 5;
  localparam int CTRL_ADDR_W     = 6;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hBF;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int NIBBLE_W                = 4;
  localparam logic [NIBBLE_W-1:0] NIBBLE_RESET = 4'h0;

  // Indirect internal map
  localparam logic [CTRL_ADDR_W-1:0] INT_SIG_FIRST = 6'h01;
  localparam logic [CTRL_ADDR_W-1:0] INT_SIG_LAST  = 6'h18;
  localparam logic [CTRL_ADDR_W-1:0] INT_CONFIG    = 6'h20;
  localparam logic [CTRL_ADDR_W-1:0] INT_OPT_FIRST = 6'h21;
  localparam logic [CTRL_ADDR_W-1:0] INT_OPT_LAST  = 6'h38;

  // Per-channel receive option fields
  localparam int OPT_INVERT_BIT   = 3;
  localparam int OPT_FIX_BIT      = 2;
  localparam int OPT_LEVEL_BIT    = 1;
  localparam int OPT_DEBOUNCE_BIT = 0;

  // Signalling nibble: A in bit 3 down to D in bit 0
  localparam int SIG_A_BIT = 3;
  localparam int SIG_B_BIT = 2;
  localparam int SIG_C_BIT = 1;
  localparam int SIG_D_BIT = 0;

  // Access timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int ACCESS_TIME_NS  = 640;
  localparam int ACCESS_CYCLES   = (ACCESS_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int COUNT_W         = 7;

  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [7:0]        data;
    logic              sig_frame;
    logic [1:0]        sig_index;
  } pcm_s;

  typedef enum logic {ACCESS_IDLE, ACCESS_RUN} access_state_e;

  // Zero-based channel index from an internal address of either bank
  function automatic logic [CHAN_W-1:0] chan_index(input logic [CTRL_ADDR_W-1:0] addr);
    chan_index = addr[CHAN_W-1:0] - 5'h01;
  endfunction : chan_index

endpackage : signalling_pkg

/* File: verilog/signalling_history.sv */
// Per-channel signalling capture, superframe history and debounce
`timescale 1ns/10ps
`default_nettype none
module signalling_history #(
  parameter int CHANNELS = signalling_pkg::CHANNELS
) (
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  input  wire logic                              capture_en,
  input  wire logic [signalling_pkg::CHAN_W-1:0] capture_channel,
  input  wire logic [1:0]                        capture_index,
  input  wire logic                              capture_bit,
  input  wire logic                              superframe_end,
  input  wire logic [CHANNELS-1:0]               debounce_mask,
  input  wire logic [signalling_pkg::CHAN_W-1:0] read_channel,
  output logic [3:0]                             read_state
);

  typedef struct packed {
    logic [CHANNELS-1:0][3:0] cap;
    logic [CHANNELS-1:0][3:0] hist1;
    logic [CHANNELS-1:0][3:0] hist2;
    logic [CHANNELS-1:0][3:0] visible;
  } history_s;

  history_s state_reg;
  history_s state_next;

  always_comb begin
    state_next = state_reg;
    if (capture_en) begin
      state_next.cap[capture_channel][signalling_pkg::SIG_A_BIT - int'(capture_index)] =
        capture_bit;
    end
    if (superframe_end) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        state_next.hist1[ch] = state_next.cap[ch];
        state_next.hist2[ch] = state_reg.hist1[ch];
        // Visible state lags the newest superframe by two
        if (!debounce_mask[ch]) begin
          state_next.visible[ch] = state_reg.hist2[ch];
        end else if (state_reg.hist2[ch] == state_reg.hist1[ch]) begin
          state_next.visible[ch] = state_reg.hist2[ch];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign read_state = state_reg.visible[read_channel];

endmodule : signalling_history
`default_nettype wire

/* File: sim/signalling_indirect_access_properties.sv */
// Port-level properties of the indirect access path and receive stream
`timescale 1ns/10ps
`default_nettype none
module signalling_indirect_access_properties #(
  parameter int CHANNELS      = signalling_pkg::CHANNELS,
  parameter int ACCESS_CYCLES = signalling_pkg::ACCESS_CYCLES
) (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic [7:0]           cpu_addr,
  input wire logic [7:0]           cpu_wdata,
  input wire logic                 cpu_wr,
  input wire logic                 cpu_rd,
  input wire logic [7:0]           cpu_rdata,
  input wire logic                 rx_valid,
  input wire signalling_pkg::pcm_s rx_word,
  input wire logic                 rx_superframe_end,
  input wire logic                 out_valid,
  input wire signalling_pkg::pcm_s out_word
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_valid_follows; rx_valid |=> out_valid; endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("valid not passed on");
  property p_valid_quiet; !rx_valid |=> !out_valid && $stable(out_word); endproperty
  a_valid_quiet: assert property (p_valid_quiet) else $error("output moved when idle");
  property p_frame_pass;
    rx_valid && rx_word.channel == 5'h00 |=> out_word == $past(rx_word);
  endproperty
  a_frame_pass: assert property (p_frame_pass) else $error("framing bit altered");
  property p_outside_pass;
    rx_valid && rx_word.channel > CHANNELS |=> out_word == $past(rx_word);
  endproperty
  a_outside_pass: assert property (p_outside_pass) else $error("spare slot altered");
  property p_fields_kept;
    rx_valid |=> out_word.channel == $past(rx_word.channel)
      && out_word.sig_frame == $past(rx_word.sig_frame)
      && out_word.sig_index == $past(rx_word.sig_index);
  endproperty
  a_fields_kept: assert property (p_fields_kept) else $error("word tags altered");
  property p_unmapped_zero;
    cpu_rd && (cpu_addr < 8'h40 || cpu_addr > 8'h43) |=> cpu_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read set");
  property p_status_low; cpu_rd && cpu_addr == 8'h41 |=> cpu_rdata[6:0] == 7'h00; endproperty
  a_status_low: assert property (p_status_low) else $error("status spare bits set");
  property p_nibble_only; cpu_rd && cpu_addr == 8'h43 |=> cpu_rdata[7:4] == 4'h0; endproperty
  a_nibble_only: assert property (p_nibble_only) else $error("buffer upper bits set");
  property p_ctrl_gap; cpu_rd && cpu_addr == 8'h42 |=> !cpu_rdata[6]; endproperty
  a_ctrl_gap: assert property (p_ctrl_gap) else $error("control bit 6 set");
  property p_rdata_hold; !cpu_rd |=> $stable(cpu_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : signalling_indirect_access_properties

bind signalling_indirect_access signalling_indirect_access_properties #(
  .CHANNELS(CHANNELS), .ACCESS_CYCLES(ACCESS_CYCLES)
) props (.clock(clock), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .rx_valid(rx_valid),
  .rx_word(rx_word), .rx_superframe_end(rx_superframe_end), .out_valid(out_valid),
  .out_word(out_word));
`default_nettype wire

/* File: sim/signalling_indirect_access_tb.sv */
// Self-checking bench for the indirect access path and receive stream
`timescale 1ns/10ps
`default_nettype none
module signalling_indirect_access_tb;
  localparam int AC = 4;
  logic                 clock, rst_n, cpu_wr, cpu_rd, rx_valid, rx_superframe_end, out_valid;
  logic [7:0]           cpu_addr, cpu_wdata, cpu_rdata, v, cfg;
  logic [3:0]           opt_m [1:24];
  logic [3:0]           h1, h2, vis, st, nv;
  logic [5:0]           a;
  logic [31:0]          r;
  signalling_pkg::pcm_s rx_word, out_word, w;
  int                   n_fail, compares, seed, i, k, ch;

  signalling_indirect_access #(.ACCESS_CYCLES(AC)) DUT (.clock(clock), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .rx_valid(rx_valid), .rx_word(rx_word),
    .rx_superframe_end(rx_superframe_end), .out_valid(out_valid), .out_word(out_word));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic fail(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask : chk_byte
  task automatic chk_word(input signalling_pkg::pcm_s got, input signalling_pkg::pcm_s exp);
    compares++;
    if (got !== exp) fail("stream word");
  endtask : chk_word
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock);
    cpu_wr = 1'b1;
    cpu_addr = ad;
    cpu_wdata = d;
    @(negedge clock);
    cpu_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge clock);
    cpu_rd = 1'b1;
    cpu_addr = ad;
    @(negedge clock);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask : rd
  task automatic launch(input logic rw, input logic [5:0] ad, input logic busy_exp);
    logic [7:0] s;
    int n;
    n = 0;
    wr(8'h42, {rw, 1'b0, ad});
    rd(8'h41, s);
    chk_byte(s, {busy_exp, 7'h00}, "busy after launch");
    while (s[7] !== 1'b0 && n < 50) begin
      rd(8'h41, s);
      n++;
    end
    if (n == 50) fail("busy stuck");
    if (busy_exp) chk_byte(8'(n), 8'(AC / 2), "busy length");
  endtask : launch
  task automatic ind_write(input logic [5:0] ad, input logic [3:0] d, input logic busy_exp);
    wr(8'h43, {4'h0, d});
    launch(1'b0, ad, busy_exp);
  endtask : ind_write
  task automatic ind_check(input logic [5:0] ad, input logic [3:0] exp, input string m);
    launch(1'b1, ad, 1'b1);
    rd(8'h43, v);
    chk_byte(v, {4'h0, exp}, m);
  endtask : ind_check

  function automatic logic [7:0] exp_pcm(input logic [7:0] d, input logic [3:0] o,
                                         input logic [7:0] c);
    logic [7:0] x;
    x = d;
    if (c[0] && o[3]) x = ~d;
    if (c[0] && o[2] && (c[4] || !c[2])) x[0] = o[1] ^ o[3];
    return x;
  endfunction : exp_pcm
  task automatic send(input signalling_pkg::pcm_s x, input logic [3:0] o);
    signalling_pkg::pcm_s e;
    e = x;
    e.data = exp_pcm(x.data, o, cfg);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_word = x;
    @(negedge clock);
    rx_valid = 1'b0;
    chk_word(out_word, e);
  endtask : send

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    #200000;
    fail("watchdog expired");
    conclude();
  end

  initial begin
    seed = 32'hC906;
    {cpu_wr, cpu_rd, rx_valid, rx_superframe_end, cpu_addr, cpu_wdata} = '0;
    rx_word = '0;
    {cfg, h1, h2, vis, st} = '0;
    for (i = 1; i <= 24; i++) opt_m[i] = 4'h0;
    rst_n = 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    for (i = 8'h3F; i <= 8'h44; i++) begin
      rd(i[7:0], v);
      chk_byte(v, 8'h00, "reset value");
    end
    $display("test reset done");
    ind_write(6'h21, 4'hF, 1'b0);
    cfg = 8'h03;
    wr(8'h40, cfg);
    ind_check(6'h21, 4'h0, "launch without indirect mode");
    $display("test refused launch done");
    for (i = 1; i <= 24; i++) begin
      r = $random(seed);
      opt_m[i] = r[3:0];
      ind_write(6'h20 + 6'(i), opt_m[i], 1'b1);
    end
    for (i = 24; i >= 1; i--) ind_check(6'h20 + 6'(i), opt_m[i], "option readback");
    ind_check(6'h20, cfg[3:0], "config readback");
    wr(8'h43, 8'h0A);
    ind_check(6'h19, 4'hA, "ignored signalling slot");
    ind_check(6'h3F, 4'hA, "ignored option slot");
    wr(8'h43, 8'h05);
    launch(1'b0, 6'h39, 1'b1);
    ind_check(6'h38, opt_m[24], "write to ignored slot");
    $display("test option map done");
    for (k = 0; k < 60; k++) begin
      if (k == 20 || k == 40) begin
        cfg = (k == 20) ? 8'h02 : 8'h07;
        wr(8'h40, cfg);
      end
      r = $random(seed);
      w = r[15:0];
      ch = {27'h0, w.channel} % 28;
      w.channel = ch[4:0];
      send(w, (ch >= 1 && ch <= 24) ? opt_m[ch] : 4'h0);
    end
    $display("test stream done");
    cfg = 8'h13;
    wr(8'h40, cfg);
    ch = 5;
    opt_m[5] = 4'h0;
    ind_write(6'h25, 4'h0, 1'b1);
    for (k = 0; k < 24; k++) begin
      if (k == 8 || k == 16) begin
        opt_m[5] = {3'h0, k == 8};
        ind_write(6'h25, opt_m[5], 1'b1);
      end
      if (k == 12) begin
        cfg = 8'h03;
        wr(8'h40, cfg);
      end
      r = $random(seed);
      if (k % 3 == 0) st = r[7:4];
      for (i = 0; i < 4; i++) begin
        w = r[15:0];
        w.channel = 5'h05;
        w.sig_frame = 1'b1;
        w.sig_index = i[1:0];
        w.data[0] = st[3 - i];
        send(w, opt_m[5]);
      end
      @(negedge clock) rx_superframe_end = 1'b1;
      @(negedge clock) rx_superframe_end = 1'b0;
      nv = (cfg[0] && opt_m[5][0]) ? ((h2 == h1) ? h2 : vis) : h2;
      h2 = h1;
      h1 = st;
      vis = nv;
      ind_check(6'h05, cfg[4] ? vis : {vis[3:2], vis[3:2]}, "signalling");
    end
    $display("test signalling done");
    conclude();
  end
endmodule : signalling_indirect_access_tb
`default_nettype wire
